// ### hdl/nas_supervisor.sv
// Alarm supervisor: detects no-data, position and heading alarms, drives the
// alarm switch, sounder and message latch, freezes or blanks nav outputs,
// and runs a hardware watchdog. Assumes sensor inputs come from logic on pclk
// and the two page buttons come straight from pins.
`timescale 1ns/10ps

// Notes on behaviour
// R1: Three alarms: position, heading, lack of data, each with own condition.
// R2: Separate heading and position enables; enable-all and disable-all commands.
// R3: No-data alarm is enabled whenever any other alarm is enabled.
// R4: Sounder on while alarm persists and unacknowledged, only if sound enabled.
// R5: Installer wires alarm switch to external panel, silences display sounder.
// R6: No-data alarm when no sensor data arrived in the last second.
// R7: Position alarm when position invalid: too few satellites or HDOP over limit.
// R8: HDOP limit resets to 4 and is writable.
// R9: Heading alarm on reduced or on invalid heading, chosen by a setting.
// R10: After power-up alarm switch active until position and heading valid; restart message.
// R11: Alarm message stays latched until either page button is pressed.
// R12: During heading alarm, heading is blanked and not emitted.
// R13: During position alarm, last valid position and fix time are held.
// R14: With alarm response off, no alarm is ever raised.
// R15: Position alarm after two seconds without valid position.
// R16: Heading alarm sixty seconds after heading turned bad.
// R17: Both position and heading alarms give one combined message.
// R18: Restart message at power-up and after watchdog restart.
// R19: Hardware watchdog restarts the system when software stops servicing it.
// R20: After watchdog restart alarm switch signals alarm within five seconds.
// R21: Any button press silences sounder; visual alarm stays until fault clears.
// R22: Position invalid below 4 satellites, or below 3 with height aiding.
// R23: One-second tick times all alarms; timers restart when condition is valid.
// R24: A new alarm re-arms sounder and message latch despite earlier acknowledge.
module nas_supervisor
  import nas_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic           pclk,                  // APB clock, 10 MHz
  input  wire logic           presetn,               // Async reset, active low
  input  wire logic           psel,                  // APB select
  input  wire logic           penable,               // APB enable
  input  wire logic           pwrite,                // APB write
  input  wire logic [11:0]    paddr,                 // APB byte address
  input  wire logic [31:0]    pwdata,                // APB write data
  output logic      [31:0]    prdata,                // APB read data
  output logic                pready,                // APB ready
  output logic                pslverr,               // APB error, unmapped
  input  wire nas_sensor_type sens,                  // Sensor status and data
  input  wire logic           heading_page_button,   // Button pin, high = pressed
  input  wire logic           position_page_button,  // Button pin, high = pressed
  output nas_nav_type         nav,                   // Navigation outputs
  output logic                alarm_switch,          // To external alarm panel
  output logic                sounder,               // Audible alarm
  output logic                visual_alarm,          // Any alarm persists
  output logic                msg_pending,           // Alarm text latched
  output nas_msg_type         msg_code,              // Latched message
  output logic                sys_restart            // Watchdog restart pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  btn_h;
    logic [2:0]  btn_p;
    logic        lvl_h;
    logic        lvl_p;
    logic [23:0] tick_cnt;
    logic        seen;
    logic        nodata;
    logic [5:0]  pos_cnt;
    logic [6:0]  hdg_cnt;
    logic [2:0]  act;
    logic        acked;
    logic        hold;
    logic        hdg_en;
    logic        pos_en;
    logic        sound_en;
    logic        respond;
    logic        hdg_inv;
    logic        wd_en;
    logic [5:0]  wd_cnt;
    logic [7:0]  hdop_lim;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    nas_nav_type nav;
    logic        alarm_switch;
    logic        sounder;
    logic        visual;
    logic        msg_pending;
    nas_msg_type msg_code;
    logic        sys_restart;
  } nas_state_type;

  nas_state_type q;
  nas_state_type d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [11:0] a);
    logic h;
    h = 1'b0;
    if (a == OFS_CTRL) begin
      h = 1'b1;
    end else if (a == OFS_HDOP) begin
      h = 1'b1;
    end else if (a == OFS_STAT) begin
      h = 1'b1;
    end else if (a == OFS_WDOG) begin
      h = 1'b1;
    end
    return h;
  endfunction

  function automatic nas_msg_type msg_of(input logic [2:0] a);
    nas_msg_type m;
    m = MSG_NONE;
    if (a[AL_POS] && a[AL_HDG]) begin
      m = MSG_POS_HDG;
    end else if (a[AL_POS]) begin
      m = MSG_POS;
    end else if (a[AL_HDG]) begin
      m = MSG_HDG;
    end else if (a[AL_NOD]) begin
      m = MSG_NODATA;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        tick;
  logic        press;
  logic        sat_ok;
  logic        pos_ok;
  logic        hdg_bad;
  logic [2:0]  cond;
  logic [2:0]  en;
  logic [2:0]  act;
  logic        acc;
  logic [31:0] rd;

  always_comb begin
    d = q;
    d.sys_restart = 1'b0;

    // ----------------------
    // Button synchronisers; a level change counts once stages two and three agree
    // ----------------------
    // Levels start low like released pins, so reset gives no false press
    d.btn_h = {q.btn_h[1:0], heading_page_button};
    d.btn_p = {q.btn_p[1:0], position_page_button};
    if (q.btn_h[1] == q.btn_h[2]) begin
      d.lvl_h = q.btn_h[2];
    end
    if (q.btn_p[1] == q.btn_p[2]) begin
      d.lvl_p = q.btn_p[2];
    end
    press = (q.btn_h[1] & q.btn_h[2] & ~q.lvl_h) | (q.btn_p[1] & q.btn_p[2] & ~q.lvl_p); // R11

    // ----------------------
    // One-second timebase
    // ----------------------
    // Shared by every alarm timer so all timeouts step together
    tick = (q.tick_cnt == 24'(TICK_CYCLES_P - 1)); // R23
    d.tick_cnt = tick ? 24'h00_0000 : q.tick_cnt + 24'h00_0001;

    // ----------------------
    // Sensor arrival over the last second
    // ----------------------
    if (tick) begin
      d.nodata = ~(q.seen | sens.data_strobe); // R6
      d.seen   = 1'b0;
    end else if (sens.data_strobe) begin
      d.seen = 1'b1;
    end

    // ----------------------
    // Position validity and its timer
    // ----------------------
    // Timers saturate at their timeout so they cannot wrap back to quiet
    sat_ok = sens.sat_count >= (sens.height_aid ? SAT_MIN_AIDED : SAT_MIN); // R22
    pos_ok = sens.fix_ok & sat_ok & (sens.hdop <= q.hdop_lim); // R7
    if (pos_ok) begin
      d.pos_cnt = 6'h00; // R23
    end else if (tick && q.pos_cnt != 6'(POS_TIMEOUT_S)) begin
      d.pos_cnt = q.pos_cnt + 6'h01;
    end

    // ----------------------
    // Heading validity and its timer
    // ----------------------
    hdg_bad = q.hdg_inv ? sens.hdg_invalid : (sens.hdg_reduced | sens.hdg_invalid); // R9
    if (!hdg_bad) begin
      d.hdg_cnt = 7'h00; // R23
    end else if (tick && q.hdg_cnt != 7'(HDG_TIMEOUT_S)) begin
      d.hdg_cnt = q.hdg_cnt + 7'h01;
    end

    // ----------------------
    // Alarm conditions, enables and response gate
    // ----------------------
    // Response off masks every alarm, so sounder and visual alarm stay off; the hold can still drive alarm_switch
    cond[AL_POS] = (q.pos_cnt == 6'(POS_TIMEOUT_S)); // R15
    cond[AL_HDG] = (q.hdg_cnt == 7'(HDG_TIMEOUT_S)); // R16
    cond[AL_NOD] = q.nodata; // R1
    en[AL_POS]   = q.pos_en; // R2
    en[AL_HDG]   = q.hdg_en; // R2
    en[AL_NOD]   = q.pos_en | q.hdg_en; // R3
    act          = q.respond ? (cond & en) : 3'h0; // R14
    d.act        = act;

    // ----------------------
    // Message latch and acknowledge; a new alarm beats a press in the same cycle
    // ----------------------
    if (|(act & ~q.act)) begin
      d.msg_pending = 1'b1; // R24
      d.acked       = 1'b0; // R24
      d.msg_code    = msg_of(act); // R17
    end else if (press) begin
      d.msg_pending = 1'b0; // R11
      d.acked       = 1'b1; // R21
    end else if (q.msg_pending && q.msg_code != MSG_RESTART && act != 3'h0) begin
      d.msg_code = msg_of(act); // R17
    end

    // ----------------------
    // Power-up hold of the alarm switch
    // ----------------------
    // Uses both heading flags, whatever the heading alarm mode
    if (pos_ok && !(sens.hdg_reduced | sens.hdg_invalid)) begin
      d.hold = 1'b0; // R10
    end

    d.sounder      = q.sound_en & (|act) & ~d.acked; // R4
    d.visual       = |act; // R21
    d.alarm_switch = (|act) | d.hold; // R10

    // ----------------------
    // Navigation outputs
    // ----------------------
    // Position is held on any invalid sample, alarm enabled or not
    if (pos_ok) begin
      d.nav.pos      = sens.pos; // R13
      d.nav.fix_time = sens.fix_time; // R13
    end
    d.nav.heading       = act[AL_HDG] ? 16'h0000 : sens.heading; // R12
    d.nav.heading_valid = ~act[AL_HDG]; // R12

    // ----------------------
    // APB slave: one wait state, write commits at the completing edge
    // ----------------------
    // Read data is held between transfers; only the ready cycle counts
    acc = psel & penable;
    rd  = 32'h0000_0000;
    if (paddr == OFS_CTRL) begin
      rd[CB_HDG_EN]  = q.hdg_en;
      rd[CB_POS_EN]  = q.pos_en;
      rd[CB_SOUND]   = q.sound_en;
      rd[CB_RESPOND] = q.respond;
      rd[CB_HDG_INV] = q.hdg_inv;
      rd[CB_WDOG_EN] = q.wd_en;
    end else if (paddr == OFS_HDOP) begin
      rd[7:0] = q.hdop_lim;
    end else if (paddr == OFS_STAT) begin
      rd[2:0] = q.act;
      rd[3]   = q.sounder;
      rd[4]   = q.alarm_switch;
      rd[5]   = q.msg_pending;
      rd[8:6] = q.msg_code;
      rd[9]   = q.hold;
      rd[10]  = q.acked;
    end else if (paddr == OFS_WDOG) begin
      rd[5:0] = q.wd_cnt;
    end
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    if (acc && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = ~addr_hit(paddr);
      d.prdata  = pwrite ? 32'h0000_0000 : rd;
    end

    // ----------------------
    // Watchdog counts seconds once armed
    // ----------------------
    // The enable is sticky so software cannot quietly disarm it
    if (q.wd_en && tick) begin
      d.wd_cnt = q.wd_cnt + 6'h01;
    end

    if (acc && q.pready && pwrite) begin
      if (paddr == OFS_CTRL) begin
        d.hdg_en   = pwdata[CB_HDG_EN];
        d.pos_en   = pwdata[CB_POS_EN];
        d.sound_en = pwdata[CB_SOUND];
        d.respond  = pwdata[CB_RESPOND];
        d.hdg_inv  = pwdata[CB_HDG_INV];
        d.wd_en    = q.wd_en | pwdata[CB_WDOG_EN];
        if (pwdata[CB_ALL_ON]) begin
          d.hdg_en = 1'b1; // R2
          d.pos_en = 1'b1; // R2
        end else if (pwdata[CB_ALL_OFF]) begin
          d.hdg_en = 1'b0; // R2
          d.pos_en = 1'b0; // R2
        end
      end else if (paddr == OFS_HDOP) begin
        d.hdop_lim = pwdata[7:0]; // R8
      end else if (paddr == OFS_WDOG && pwdata[15:0] == WDOG_KEY) begin
        d.wd_cnt = 6'h00; // R19
      end
    end

    // ----------------------
    // Watchdog expiry restarts the alarm state as at power-up; control, HDOP limit and nav outputs keep their values
    // ----------------------
    // Placed last so it overrides the timer, alarm, message and watchdog updates above in this cycle
    if (q.wd_cnt == 6'(WDOG_TIMEOUT_S)) begin
      d.sys_restart  = 1'b1; // R19
      d.wd_cnt       = 6'h00;
      d.seen         = 1'b0;
      d.nodata       = 1'b0;
      d.pos_cnt      = 6'h00;
      d.hdg_cnt      = 7'h00;
      d.act          = 3'h0;
      d.hold         = 1'b1; // R20
      d.alarm_switch = 1'b1; // R20
      d.msg_pending  = 1'b1; // R18
      d.msg_code     = MSG_RESTART; // R18
      d.acked        = 1'b0;
      d.sounder      = 1'b0;
      d.visual       = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q              <= '0;
      q.hdg_en       <= HDG_EN_RST;
      q.pos_en       <= POS_EN_RST;
      q.sound_en     <= SOUND_RST;
      q.respond      <= RESPOND_RST;
      q.hdg_inv      <= HDG_INV_RST;
      q.hdop_lim     <= HDOP_RST; // R8
      q.hold         <= 1'b1; // R10
      q.alarm_switch <= 1'b1; // R10
      q.msg_pending  <= 1'b1; // R18
      q.msg_code     <= MSG_RESTART; // R18
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign nav          = q.nav;
  assign alarm_switch = q.alarm_switch;
  assign sounder      = q.sounder;
  assign visual_alarm = q.visual;
  assign msg_pending  = q.msg_pending;
  assign msg_code     = q.msg_code;
  assign sys_restart  = q.sys_restart;

endmodule

// ### hdl/nas_pkg.sv
// Constants, message codes and carrier types of the navigation alarm supervisor.
// Assumes a 10 MHz APB clock; all alarm timing runs off a derived one-second tick.
package nas_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int TICK_S          = 1;
  localparam int TICK_CYCLES     = TICK_S * CLK_HZ;
  localparam int POS_TIMEOUT_S   = 2;
  localparam int HDG_TIMEOUT_S   = 60;
  localparam int WDOG_TIMEOUT_S  = 2;

  // ----------------------------------------------------------------
  // Position validity
  // ----------------------------------------------------------------
  localparam logic [4:0] SAT_MIN       = 5'h04;
  localparam logic [4:0] SAT_MIN_AIDED = 5'h03;
  localparam logic [7:0] HDOP_RST      = 8'h04;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_HDOP = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_WDOG = 12'h00C;

  localparam int CB_HDG_EN  = 0;
  localparam int CB_POS_EN  = 1;
  localparam int CB_SOUND   = 2;
  localparam int CB_RESPOND = 3;
  localparam int CB_HDG_INV = 4;
  localparam int CB_ALL_ON  = 5;
  localparam int CB_ALL_OFF = 6;
  localparam int CB_WDOG_EN = 7;

  localparam logic HDG_EN_RST  = 1'b1;
  localparam logic POS_EN_RST  = 1'b1;
  localparam logic SOUND_RST   = 1'b1;
  localparam logic RESPOND_RST = 1'b1;
  localparam logic HDG_INV_RST = 1'b0;

  localparam logic [15:0] WDOG_KEY = 16'hA5C3;

  // Alarm index within the three-bit alarm vectors
  localparam int AL_POS = 0;
  localparam int AL_HDG = 1;
  localparam int AL_NOD = 2;

  typedef enum logic [2:0] {
    MSG_NONE,
    MSG_POS,
    MSG_HDG,
    MSG_POS_HDG,
    MSG_NODATA,
    MSG_RESTART
  } nas_msg_type;

  typedef struct packed {
    logic        data_strobe;  // One-cycle pulse per sensor message
    logic [4:0]  sat_count;
    logic [7:0]  hdop;
    logic        height_aid;
    logic        fix_ok;
    logic        hdg_reduced;
    logic        hdg_invalid;
    logic [47:0] pos;
    logic [16:0] fix_time;
    logic [15:0] heading;
  } nas_sensor_type;

  typedef struct packed {
    logic [47:0] pos;
    logic [16:0] fix_time;
    logic [15:0] heading;
    logic        heading_valid;
  } nas_nav_type;

endpackage

// ### tb/nas_monitor.sv
// Concurrent checks on the alarm supervisor ports.
// Assumes one clock, pclk, and async active-low presetn.
`timescale 1ns/10ps
module nas_monitor
  import nas_pkg::*;
(
  input wire logic           pclk,                  // Clock
  input wire logic           presetn,               // Reset
  input wire logic           psel,                  // APB select
  input wire logic           penable,               // APB enable
  input wire logic           pready,                // APB ready
  input wire logic           pslverr,               // APB error
  input wire nas_sensor_type sens,                  // Sensor inputs
  input wire logic           heading_page_button,   // Button
  input wire logic           position_page_button,  // Button
  input wire nas_nav_type    nav,                   // Nav outputs
  input wire logic           alarm_switch,          // Panel output
  input wire logic           sounder,               // Sounder
  input wire logic           visual_alarm,          // Visual alarm
  input wire logic           msg_pending,           // Text latched
  input wire nas_msg_type    msg_code,              // Message
  input wire logic           sys_restart            // Restart pulse
);
  // ----------------------------------------
  // Cycles since a button was last high
  // ----------------------------------------
  logic [3:0] since_btn_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_btn_q <= 4'hF;
    else if (heading_page_button || position_page_button)
      since_btn_q <= 4'h0;
    else if (since_btn_q != 4'hF)
      since_btn_q <= since_btn_q + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_access;
    psel && penable && !pready ##1 pready;
  endsequence
  property p_apb_wait; psel && !penable |=> s_access; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_sound; sounder |-> visual_alarm; endproperty
  property p_switch; !alarm_switch |-> !visual_alarm; endproperty
  property p_ack; $fell(msg_pending) |-> since_btn_q <= 4'h6; endproperty
  property p_blank; !nav.heading_valid |-> nav.heading == 16'h0000; endproperty
  property p_hold; !sens.fix_ok || (!sens.height_aid && sens.sat_count < SAT_MIN) |=> $stable(nav.pos); endproperty
  property p_restart; sys_restart |-> ##[0:1] (alarm_switch && msg_code == MSG_RESTART); endproperty
  property p_pulse; sys_restart |=> !sys_restart; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer not after one wait state");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_sound: assert property (p_sound) else $error("sounder without alarm");
  a_switch: assert property (p_switch) else $error("alarm without alarm switch");
  a_ack: assert property (p_ack) else $error("message cleared without press");
  a_blank: assert property (p_blank) else $error("heading not blanked");
  a_hold: assert property (p_hold) else $error("position changed while invalid");
  a_restart: assert property (p_restart) else $error("restart without alarm switch");
  a_pulse: assert property (p_pulse) else $error("restart pulse too long");
endmodule

bind nas_supervisor nas_monitor u_nas_monitor (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .sens,
  .heading_page_button, .position_page_button, .nav, .alarm_switch, .sounder, .visual_alarm, .msg_pending,
  .msg_code, .sys_restart);

// ### tb/nas_panel.sv
// Model of the alarm panel and the two page buttons.
// Assumes press requests arrive as one-cycle pulses on pclk.
`timescale 1ns/10ps
module nas_panel (
  input wire logic        pclk,                  // Clock
  input wire logic        presetn,               // Reset
  input wire logic [1:0]  press,                 // Press request
  input wire logic        alarm_switch,          // From supervisor
  output logic            heading_page_button,   // Button pin
  output logic            position_page_button,  // Button pin
  output int              alarms_seen            // Panel activations
);
  logic [3:0] hold_q;
  logic       sw_q;
  // Button held several cycles like a finger press
  always @(posedge pclk) begin
    if (press != 2'b00) begin
      hold_q <= 4'h6;
      heading_page_button <= press[0];
      position_page_button <= press[1];
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end else begin
      heading_page_button <= 1'b0;
      position_page_button <= 1'b0;
    end
  end
  // Panel counts each alarm switch activation
  always @(posedge pclk) begin
    sw_q <= alarm_switch;
    if (presetn && alarm_switch && !sw_q)
      alarms_seen <= alarms_seen + 1;
  end
  initial begin
    hold_q = 4'h0;
    sw_q = 1'b0;
    alarms_seen = 0;
    heading_page_button = 1'b0;
    position_page_button = 1'b0;
  end
endmodule

// ### tb/nas_supervisor_tb.sv
// Self-checking bench for the alarm supervisor.
// Assumes a short tick of TK cycles set through TICK_CYCLES_P.
`timescale 1ns/10ps
module nas_supervisor_tb;
  import nas_pkg::*;
  localparam int TK = 20;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, feed;
  logic           alarm_switch, sounder, visual_alarm, msg_pending, sys_restart;
  logic           heading_page_button, position_page_button;
  logic [1:0]     press;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd, seed;
  nas_sensor_type sens;
  nas_nav_type    nav;
  nas_msg_type    msg_code;
  int             err_count, checks, n, seen;

  nas_supervisor #(.TICK_CYCLES_P(TK)) u_nas_supervisor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sens, .heading_page_button, .position_page_button, .nav,
    .alarm_switch, .sounder, .visual_alarm, .msg_pending, .msg_code, .sys_restart);
  nas_panel u_nas_panel (.pclk, .presetn, .press, .alarm_switch, .heading_page_button,
    .position_page_button, .alarms_seen(seen));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) sens.data_strobe <= feed & ~sens.data_strobe;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pos_bad(nas_sensor_type s, logic [7:0] lim);
    return !s.fix_ok || s.hdop > lim || s.sat_count < (s.height_aid ? SAT_MIN_AIDED : SAT_MIN);
  endfunction
  task automatic cmp(input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20)
      err_count++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tk(input int t);
    repeat (t * TK + 6) @(posedge pclk);
  endtask
  task automatic btn(input logic [1:0] k);
    press <= k;
    @(posedge pclk);
    press <= 2'b00;
    repeat (14) @(posedge pclk);
  endtask
  task automatic set_sens(input logic [4:0] sat, input logic aid, input logic [7:0] hd, input logic hr);
    logic [31:0] r;
    r = rnd();
    sens.sat_count <= sat;
    sens.height_aid <= aid;
    sens.hdop <= hd;
    sens.hdg_reduced <= hr;
    sens.fix_ok <= 1'b1;
    sens.pos <= {r[15:0], r};
    sens.heading <= r[31:16];
    sens.fix_time <= r[16:0];
  endtask
  task summarize();
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, press, feed, presetn} = '0;
    sens = '0;
    err_count = 0;
    checks = 0;
    seed = 32'h0000_0008;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp(msg_code, MSG_RESTART);
    cmp(alarm_switch, 1'b1);
    apb(1'b0, OFS_HDOP, 32'h0000_0000);
    cmp(rd, HDOP_RST);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    cmp(rd[4:0], 5'h0F);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp(perr, 1'b1);
    feed <= 1'b1;
    set_sens(5'(4 + rnd() % 28), 1'b0, 8'(rnd() % 5), 1'b0);
    tk(1);
    cmp(alarm_switch, 1'b0);
    cmp(nav.pos, sens.pos);
    btn(2'b10);
    cmp(msg_pending, 1'b0);
    set_sens(5'h03, 1'b0, 8'h00, 1'b0);
    repeat (TK - 8) @(posedge pclk);
    cmp(visual_alarm, 1'b0);
    tk(2);
    cmp(visual_alarm, pos_bad(sens, HDOP_RST));
    cmp({sounder, msg_code}, {1'b1, MSG_POS});
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    cmp(rd[2:0], 3'b001);
    btn(2'b01);
    cmp({sounder, visual_alarm, msg_pending}, 3'b010);
    set_sens(5'h03, 1'b1, 8'h00, 1'b0);
    tk(2);
    cmp(visual_alarm, pos_bad(sens, HDOP_RST));
    apb(1'b1, OFS_HDOP, 32'h0000_0006);
    set_sens(5'h1F, 1'b0, 8'h06, 1'b0);
    tk(3);
    cmp(visual_alarm, 1'b0);
    set_sens(5'h1F, 1'b0, 8'h07, 1'b1);
    tk(3);
    cmp(visual_alarm, 1'b1);
    btn(2'b01);
    repeat (52 * TK) @(posedge pclk);
    cmp(nav.heading_valid, 1'b1);
    tk(6);
    cmp({nav.heading_valid, msg_pending, sounder, msg_code}, {3'b011, MSG_POS_HDG});
    set_sens(5'h1F, 1'b0, 8'h00, 1'b0);
    tk(2);
    cmp(visual_alarm, 1'b0);
    feed <= 1'b0;
    tk(2);
    cmp({visual_alarm, msg_code}, {1'b1, MSG_NODATA});
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    tk(2);
    cmp(visual_alarm, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0048);
    tk(2);
    cmp(visual_alarm, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0028);
    tk(2);
    cmp(visual_alarm, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    cmp(rd[1:0], 2'b11);
    feed <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_001F);
    set_sens(5'h1F, 1'b0, 8'h00, 1'b1);
    repeat (62 * TK) @(posedge pclk);
    cmp({nav.heading_valid, visual_alarm}, 2'b10);
    apb(1'b1, OFS_CTRL, 32'h0000_008F);
    apb(1'b1, OFS_WDOG, {16'h0000, WDOG_KEY});
    repeat (TK) @(posedge pclk);
    cmp(sys_restart, 1'b0);
    n = 0;
    while (sys_restart !== 1'b1 && n < 5 * TK) begin
      @(posedge pclk);
      n++;
    end
    cmp(n < 5 * TK, 1'b1);
    cmp({alarm_switch, msg_code}, {1'b1, MSG_RESTART});
    cmp(seen >= 3, 1'b1);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule
